// >>> psec_defs.svh
`ifndef PSEC_DEFS_SVH
`define PSEC_DEFS_SVH
// exception settle time in pipeline clocks
`define PSEC_EXC_STALL_CYCLES 2'h2
// store write hold on a store hit
`define PSEC_STORE_HOLD_CYCLES 2'h1
// cause codes loaded into the system coprocessor
`define PSEC_CAUSE_NONE 5'h00
`define PSEC_CAUSE_RESET 5'h01
`define PSEC_CAUSE_NMI 5'h02
`define PSEC_CAUSE_OVFL 5'h03
`define PSEC_CAUSE_TRAP 5'h04
`define PSEC_CAUSE_FPE 5'h05
`define PSEC_CAUSE_CP2E 5'h06
`define PSEC_CAUSE_DADE 5'h07
`define PSEC_CAUSE_DTLB_REFILL 5'h08
`define PSEC_CAUSE_DTLB_INVALID 5'h09
`define PSEC_CAUSE_DTLB_MOD 5'h0a
`define PSEC_CAUSE_WATCH 5'h0b
`define PSEC_CAUSE_INTR 5'h0c
`define PSEC_CAUSE_DBE 5'h0d
`define PSEC_CAUSE_SYSC 5'h0e
`define PSEC_CAUSE_BRPT 5'h0f
`define PSEC_CAUSE_CPU 5'h10
`define PSEC_CAUSE_RSVD 5'h11
`define PSEC_CAUSE_IADE 5'h12
`define PSEC_CAUSE_ITLB_REFILL 5'h13
`define PSEC_CAUSE_ITLB_INVALID 5'h14
`define PSEC_CAUSE_IBE 5'h15
// stage identifiers for the abort origin
`define PSEC_STG_NONE 3'h0
`define PSEC_STG_OPF 3'h1
`define PSEC_STG_ALU 3'h2
`define PSEC_STG_DAC 3'h3
`define PSEC_STG_ALL 3'h4
`endif

// >>> psec_pkg.sv
package psec_pkg;
  // data access stage exception requests
  typedef struct packed {
    logic reset;
    logic nmi;
    logic overflow;
    logic trap;
    logic fpe;
    logic cp2Exc;
    logic addrErr;
    logic tlbRefill;
    logic tlbInvalid;
    logic tlbModified;
    logic watch;
    logic intr;
    logic busErr;
  } psec_dac_exc_t;
  // alu stage exception requests
  typedef struct packed {
    logic syscall;
    logic breakpoint;
    logic copUnusable;
    logic reserved;
  } psec_alu_exc_t;
  // operand fetch stage exception requests
  typedef struct packed {
    logic addrErr;
    logic tlbRefill;
    logic tlbInvalid;
    logic busErr;
  } psec_opf_exc_t;
  // stall requests and conditions from the pipeline
  typedef struct packed {
    logic fetchMiss;
    logic itlbMiss;
    logic multicycleEnter;
    logic multicycleLast;
    logic loadUseHazard;
    logic cop2Enter;
    logic cop2Last;
    logic dacNeedsCache;
    logic dacIsLoad;
    logic dacIsStore;
    logic dcacheLookupMiss;
    logic dcacheRefillDone;
    logic icacheOpEnter;
    logic icacheOpDone;
    logic dcacheOpEnter;
    logic dcacheOpDone;
    logic syscopRead;
    logic retireExcepting;
  } psec_req_t;
  // stall outputs
  typedef struct packed {
    logic multicycle_stall;
    logic load_use_stall;
    logic coproc2_stall;
    logic dcache_miss_stall;
    logic dcache_busy_stall;
    logic cache_maint_stall;
    logic syscop_bypass_stall;
    logic fetch_miss_stall;
  } psec_stall_t;
  // exception control outputs
  typedef struct packed {
    logic abortPulse;
    logic [2:0] abortFrom;
    logic keepRetire;
    logic vectorFetch;
    logic causeWrite;
    logic [4:0] causeCode;
    logic badAddrWrite;
  } psec_exc_out_t;
  typedef enum logic [3:0] {
    PSEC_RUN = 4'h1,
    PSEC_EXC_WAIT = 4'h2,
    PSEC_ABORT = 4'h4,
    PSEC_VECTOR = 4'h8
  } psec_state_t;
  typedef struct packed {
    psec_state_t state;
    logic [1:0] excCount;
    logic [4:0] pendCause;
    logic [2:0] pendFrom;
    logic pendKeepRetire;
    logic pendBadAddr;
    logic prevRun;
    logic mcActive;
    logic cp2Active;
    logic ldActive;
    logic ldTail;
    logic missRefill;
    logic storeHold;
    logic storeMissHold;
    logic storeExtra;
    logic icOpActive;
    logic dcOpActive;
    logic bypassDone;
    logic fpeHeld;
    logic resetSync1;
    logic resetSync2;
    logic nmiSync1;
    logic nmiSync2;
    logic intrSync1;
    logic intrSync2;
    psec_stall_t stall;
    psec_exc_out_t exc;
    logic advance;
  } psec_state_reg_t;
endpackage : psec_pkg

// >>> psec_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "psec_defs.svh"
module psec_ctrl (
  input wire logic clk_sys, // pipeline clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic clkEn, // freezes all state when low
  input wire logic resetReq, // external reset pin
  input wire logic nmiReq, // external nmi pin
  input wire logic intrReq, // external interrupt pin
  input wire psec_pkg::psec_req_t req, // stall conditions
  input wire psec_pkg::psec_dac_exc_t dacExc, // data access exceptions
  input wire psec_pkg::psec_alu_exc_t aluExc, // alu exceptions
  input wire logic aluFpeDetect, // floating exception found in alu
  input wire psec_pkg::psec_opf_exc_t opfExc, // operand fetch exceptions
  input wire logic fetchRefillDone, // instruction refill complete
  output psec_pkg::psec_stall_t stall, // stall outputs
  output psec_pkg::psec_exc_out_t exc, // exception controls
  output logic advance, // pipeline advance enable
  output logic cop2Proceed, // tell coprocessor to proceed
  output logic opfHold, // operand fetch stage hold
  output logic aluHold, // alu stage hold
  output logic dacHold // data access stage hold
);
  import psec_pkg::*;

  psec_state_reg_t r;
  psec_state_reg_t next_r;

  // ************************************
  // data access, alu and operand fetch stage priority encode
  // ************************************
  function automatic logic [4:0] dacCause(input psec_dac_exc_t e, input logic fpe);
    logic [4:0] c;
    c = `PSEC_CAUSE_NONE;
    if (e.reset) c = `PSEC_CAUSE_RESET;
    else if (e.nmi) c = `PSEC_CAUSE_NMI;
    else if (e.overflow) c = `PSEC_CAUSE_OVFL;
    else if (e.trap) c = `PSEC_CAUSE_TRAP;
    else if (e.fpe || fpe) c = `PSEC_CAUSE_FPE;
    else if (e.cp2Exc) c = `PSEC_CAUSE_CP2E;
    else if (e.addrErr) c = `PSEC_CAUSE_DADE;
    else if (e.tlbRefill) c = `PSEC_CAUSE_DTLB_REFILL;
    else if (e.tlbInvalid) c = `PSEC_CAUSE_DTLB_INVALID;
    else if (e.tlbModified) c = `PSEC_CAUSE_DTLB_MOD;
    else if (e.watch) c = `PSEC_CAUSE_WATCH;
    else if (e.intr) c = `PSEC_CAUSE_INTR;
    return c;
  endfunction : dacCause

  function automatic logic [4:0] aluCause(input psec_alu_exc_t e);
    logic [4:0] c;
    c = `PSEC_CAUSE_NONE;
    if (e.syscall) c = `PSEC_CAUSE_SYSC;
    else if (e.breakpoint) c = `PSEC_CAUSE_BRPT;
    else if (e.copUnusable) c = `PSEC_CAUSE_CPU;
    else if (e.reserved) c = `PSEC_CAUSE_RSVD;
    return c;
  endfunction : aluCause

  function automatic logic [4:0] opfCause(input psec_opf_exc_t e);
    logic [4:0] c;
    c = `PSEC_CAUSE_NONE;
    if (e.addrErr) c = `PSEC_CAUSE_IADE;
    else if (e.tlbRefill) c = `PSEC_CAUSE_ITLB_REFILL;
    else if (e.tlbInvalid) c = `PSEC_CAUSE_ITLB_INVALID;
    else if (e.busErr) c = `PSEC_CAUSE_IBE;
    return c;
  endfunction : opfCause

  // ************************************
  // next state
  // ************************************
  always_comb begin
    logic running;
    logic wbStall;
    logic dacStall;
    logic aluStall;
    logic opfStall;
    logic [4:0] dC;
    logic [4:0] aC;
    logic [4:0] oC;
    logic indepExc;
    logic takeExc;
    logic [4:0] cause;
    logic [2:0] from;
    logic keepWb;
    logic badAddr;
    logic busyNow;
    logic fpeAtDac;
    running = 1'b0;
    wbStall = 1'b0;
    dacStall = 1'b0;
    aluStall = 1'b0;
    opfStall = 1'b0;
    dC = `PSEC_CAUSE_NONE;
    aC = `PSEC_CAUSE_NONE;
    oC = `PSEC_CAUSE_NONE;
    indepExc = 1'b0;
    takeExc = 1'b0;
    cause = `PSEC_CAUSE_NONE;
    from = `PSEC_STG_NONE;
    keepWb = 1'b0;
    badAddr = 1'b0;
    busyNow = 1'b0;
    fpeAtDac = 1'b0;
    next_r = r;
    // pins pass two flops first
    next_r.resetSync1 = resetReq;
    next_r.resetSync2 = r.resetSync1;
    next_r.nmiSync1 = nmiReq;
    next_r.nmiSync2 = r.nmiSync1;
    next_r.intrSync1 = intrReq;
    next_r.intrSync2 = r.intrSync1;
    next_r.exc.abortPulse = 1'b0;
    next_r.exc.causeWrite = 1'b0;
    next_r.exc.badAddrWrite = 1'b0;
    next_r.exc.vectorFetch = 1'b0;
    running = (r.state == PSEC_RUN);
    // ************************************
    // stall tracking
    // ************************************
    if (running) begin
      // retire stage bypass hazard, one clock
      next_r.stall.syscop_bypass_stall = req.retireExcepting && req.syscopRead && !r.bypassDone;
      next_r.bypassDone = next_r.stall.syscop_bypass_stall;
      // miss stall only in the lookup cycle
      next_r.stall.dcache_miss_stall = req.dcacheLookupMiss && !r.missRefill && (req.dacIsLoad || req.dacIsStore);
      if (next_r.stall.dcache_miss_stall) next_r.missRefill = 1'b1;
      if (r.missRefill && req.dcacheRefillDone) next_r.missRefill = 1'b0;
      // store then cache user: one clock hold on hit
      if (r.storeHold) begin
        next_r.storeHold = 1'b0;
      end else begin
        next_r.storeHold = req.dacNeedsCache && !r.storeMissHold && r.storeExtra;
      end
      // store miss: hold until refill, then extra cycle if follower uses cache
      if (req.dacIsStore && req.dcacheLookupMiss && !r.storeMissHold) next_r.storeMissHold = 1'b1;
      if (r.storeMissHold && req.dcacheRefillDone) begin
        next_r.storeMissHold = 1'b0;
        next_r.storeExtra = req.dacNeedsCache;
      end else begin
        next_r.storeExtra = req.dacIsStore && !req.dcacheLookupMiss && !r.storeExtra && !r.storeHold;
      end
      busyNow = r.missRefill || r.storeMissHold || r.storeHold;
      next_r.stall.dcache_busy_stall = next_r.missRefill || next_r.storeMissHold || next_r.storeHold;
      // cache maintenance
      if (req.icacheOpEnter) next_r.icOpActive = 1'b1;
      if (r.icOpActive && req.icacheOpDone) next_r.icOpActive = 1'b0;
      if (req.dcacheOpEnter) next_r.dcOpActive = 1'b1;
      if (r.dcOpActive && req.dcacheOpDone) next_r.dcOpActive = 1'b0;
      next_r.stall.cache_maint_stall = next_r.icOpActive || next_r.dcOpActive;
      // load use: one clock on hit, one beyond busy on miss
      if (req.loadUseHazard && !r.ldActive) next_r.ldActive = 1'b1;
      else if (r.ldActive && !busyNow && !req.dcacheLookupMiss) next_r.ldActive = 1'b0;
      next_r.stall.load_use_stall = next_r.ldActive;
      // multicycle and coprocessor: drop in final clock
      if (req.multicycleEnter) next_r.mcActive = 1'b1;
      if (req.multicycleLast) next_r.mcActive = 1'b0;
      next_r.stall.multicycle_stall = next_r.mcActive && !req.multicycleLast;
      if (req.cop2Enter) next_r.cp2Active = 1'b1;
      if (req.cop2Last) next_r.cp2Active = 1'b0;
      next_r.stall.coproc2_stall = next_r.cp2Active && !req.cop2Last;
      // fetch miss, bus error waits for refill
      next_r.stall.fetch_miss_stall = req.fetchMiss || req.itlbMiss;
      // floating exception held in alu while fetch stalls
      if (aluFpeDetect) next_r.fpeHeld = 1'b1;
    end
    wbStall = r.stall.syscop_bypass_stall;
    dacStall = r.stall.dcache_miss_stall || r.stall.dcache_busy_stall || r.stall.cache_maint_stall;
    aluStall = r.stall.load_use_stall || r.stall.multicycle_stall || r.stall.coproc2_stall;
    opfStall = r.stall.fetch_miss_stall;
    // ************************************
    // exception arbitration
    // ************************************
    fpeAtDac = r.fpeHeld && r.advance;
    dC = dacCause(dacExc, fpeAtDac);
    aC = aluCause(aluExc);
    oC = (fetchRefillDone || !opfStall) ? opfCause(opfExc) : `PSEC_CAUSE_NONE;
    if (running) begin
      if (r.resetSync2) begin
        indepExc = 1'b1;
        cause = `PSEC_CAUSE_RESET;
      end else if (r.prevRun && r.nmiSync2) begin
        indepExc = 1'b1;
        cause = `PSEC_CAUSE_NMI;
      end else if (r.prevRun && r.intrSync2 && dC == `PSEC_CAUSE_NONE) begin
        indepExc = 1'b1;
        cause = `PSEC_CAUSE_INTR;
      end
      if (indepExc) begin
        takeExc = 1'b1;
        from = `PSEC_STG_ALL;
        keepWb = 1'b1;
      end else if (dC != `PSEC_CAUSE_NONE && !wbStall) begin
        takeExc = 1'b1;
        cause = dC;
        from = `PSEC_STG_DAC;
        badAddr = dacExc.addrErr || dacExc.tlbRefill || dacExc.tlbInvalid || dacExc.tlbModified;
      end else if (dacExc.busErr && !wbStall && !dacStall) begin
        takeExc = 1'b1;
        cause = `PSEC_CAUSE_DBE;
        from = `PSEC_STG_DAC;
      end else if (aC != `PSEC_CAUSE_NONE && !wbStall && !dacStall) begin
        takeExc = 1'b1;
        cause = aC;
        from = `PSEC_STG_ALU;
      end else if (oC != `PSEC_CAUSE_NONE && !wbStall && !dacStall && !aluStall) begin
        takeExc = 1'b1;
        cause = oC;
        from = `PSEC_STG_OPF;
        badAddr = opfExc.addrErr || opfExc.tlbRefill || opfExc.tlbInvalid;
      end
    end
    // ************************************
    // exception sequence
    // ************************************
    case (r.state)
      PSEC_RUN: begin
        if (takeExc) begin
          next_r.state = PSEC_EXC_WAIT;
          next_r.excCount = `PSEC_EXC_STALL_CYCLES;
          next_r.pendCause = cause;
          next_r.pendFrom = from;
          next_r.pendKeepRetire = keepWb;
          next_r.pendBadAddr = badAddr;
        end
      end
      PSEC_EXC_WAIT: begin
        next_r.excCount = r.excCount - 2'h1;
        if (r.excCount == 2'h1) next_r.state = PSEC_ABORT;
      end
      PSEC_ABORT: begin
        next_r.exc.abortPulse = 1'b1;
        next_r.exc.abortFrom = r.pendFrom;
        next_r.exc.keepRetire = r.pendKeepRetire;
        next_r.exc.causeWrite = 1'b1;
        next_r.exc.causeCode = r.pendCause;
        next_r.exc.badAddrWrite = r.pendBadAddr;
        // aborted work drops its pending requests
        next_r.stall = '0;
        next_r.mcActive = 1'b0;
        next_r.cp2Active = 1'b0;
        next_r.ldActive = 1'b0;
        next_r.missRefill = 1'b0;
        next_r.storeHold = 1'b0;
        next_r.storeMissHold = 1'b0;
        next_r.storeExtra = 1'b0;
        next_r.icOpActive = 1'b0;
        next_r.dcOpActive = 1'b0;
        next_r.fpeHeld = 1'b0;
        next_r.state = PSEC_VECTOR;
      end
      PSEC_VECTOR: begin
        next_r.exc.vectorFetch = 1'b1;
        next_r.state = PSEC_RUN;
      end
      default: next_r.state = PSEC_RUN;
    endcase
    next_r.advance = (next_r.state == PSEC_RUN) && (next_r.stall == '0);
    if (next_r.advance) next_r.fpeHeld = next_r.fpeHeld && !r.advance;
    next_r.prevRun = r.advance;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      r <= '0;
      r.state <= PSEC_RUN;
    end else if (clkEn) begin
      r <= next_r;
    end
  end

  // ************************************
  // outputs
  // ************************************
  assign stall = r.stall;
  assign exc = r.exc;
  assign advance = r.advance;
  assign cop2Proceed = r.stall.coproc2_stall;
  // all three stage holds are the inverse of advance, so the stages stall together
  assign dacHold = !r.advance;
  assign aluHold = !r.advance;
  assign opfHold = !r.advance;
endmodule : psec_ctrl
`default_nettype wire

// >>> psec_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************
// stall and abort relations at the ports
// ************************************
module psec_ctrl_checker (
  input wire logic clk_sys, // pipeline clock
  input wire logic rst_n, // sync reset
  input wire logic clkEn, // clock enable
  input wire psec_pkg::psec_req_t req, // stall conditions
  input wire psec_pkg::psec_stall_t stall, // stall levels
  input wire psec_pkg::psec_exc_out_t exc, // exception controls
  input wire logic advance, // pipeline advance
  input wire logic cop2Proceed, // coprocessor go
  input wire logic opfHold, // operand fetch hold
  input wire logic aluHold, // alu hold
  input wire logic dacHold // data access hold
);
  import psec_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  chk_hold_mirror: assert property (opfHold == !advance && aluHold == !advance && dacHold == !advance)
    else $error("stage hold differs from advance");
  chk_stall_freeze: assert property (stall != '0 |-> !advance)
    else $error("advance during stall");
  chk_cop2_go: assert property (cop2Proceed == stall.coproc2_stall)
    else $error("coprocessor go differs from its stall");
  chk_mc_release: assert property (clkEn && stall.multicycle_stall && req.multicycleLast
    |=> !stall.multicycle_stall) else $error("multicycle stall kept past last clock");
  chk_cp2_release: assert property (clkEn && stall.coproc2_stall && req.cop2Last
    |=> !stall.coproc2_stall) else $error("coprocessor stall kept past last clock");
  chk_miss_once: assert property (clkEn && stall.dcache_miss_stall |=> !stall.dcache_miss_stall)
    else $error("miss stall longer than lookup");
  chk_bypass_once: assert property (clkEn && stall.syscop_bypass_stall |=> !stall.syscop_bypass_stall)
    else $error("bypass stall longer than one clock");
  chk_abort_settle: assert property ($rose(exc.abortPulse)
    |-> !advance && !$past(advance) && !$past(advance, 2)) else $error("abort without two stall clocks");
  chk_vector_next: assert property (clkEn && exc.abortPulse |=> exc.vectorFetch && !exc.abortPulse)
    else $error("no vector fetch after abort");
  chk_cause_write: assert property (exc.abortPulse |-> exc.causeWrite)
    else $error("abort without cause capture");
  cover property (exc.abortPulse);
  cover property (stall.multicycle_stall ##1 !stall.multicycle_stall);
  cover property (stall.dcache_busy_stall ##1 !stall.dcache_busy_stall);
endmodule : psec_ctrl_checker
bind psec_ctrl psec_ctrl_checker u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn), .req(req), .stall(stall),
  .exc(exc), .advance(advance), .cop2Proceed(cop2Proceed), .opfHold(opfHold), .aluHold(aluHold), .dacHold(dacHold));
`default_nettype wire

// >>> psec_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// ******************************
// cache and coprocessor responder
// ******************************
module psec_far_model (
  input wire logic clk_sys, // pipeline clock
  input wire logic rst_n, // sync reset
  input wire logic slow, // long service time
  input wire psec_pkg::psec_stall_t stall, // stall levels
  input wire logic cop2Proceed, // coprocessor go
  output logic refillDone, // critical word ready
  output logic opDone, // maintenance done
  output logic cop2Last // coprocessor final clock
);
  import psec_pkg::*;
  logic busy;
  logic done;
  logic [3:0] cnt;
  // one service at a time, answered after one clock, or seven when slow
  assign busy = stall.dcache_busy_stall || stall.cache_maint_stall || cop2Proceed;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !busy || done) begin
      cnt <= 4'h0;
      done <= 1'b0;
    end else begin
      cnt <= cnt + 4'h1;
      done <= cnt == (slow ? 4'h6 : 4'h0);
    end
  end
  assign refillDone = done && stall.dcache_busy_stall;
  assign opDone = done && stall.cache_maint_stall;
  assign cop2Last = done && cop2Proceed;
endmodule : psec_far_model
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "psec_defs.svh"
module tb_top;
  import psec_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic slow = 1'b0;
  logic resetReq = 1'b0;
  logic intrReq = 1'b0;
  psec_req_t drv = '0;
  psec_req_t reqBus;
  psec_dac_exc_t dacExc = '0;
  psec_alu_exc_t aluExc = '0;
  psec_stall_t stall;
  psec_exc_out_t exc;
  logic advance, cop2Proceed, opfHold, aluHold, dacHold;
  logic refillDone, opDone, cop2Last;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;
  always #2 clk_sys = ~clk_sys;
  always_comb begin
    reqBus = drv;
    reqBus.dcacheRefillDone = refillDone;
    reqBus.icacheOpDone = opDone;
    reqBus.dcacheOpDone = opDone;
    reqBus.cop2Last = cop2Last;
  end
  psec_ctrl u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(1'b1), .resetReq(resetReq), .nmiReq(1'b0),
    .intrReq(intrReq), .req(reqBus), .dacExc(dacExc), .aluExc(aluExc), .aluFpeDetect(1'b0), .opfExc('0),
    .fetchRefillDone(1'b0), .stall(stall), .exc(exc), .advance(advance), .cop2Proceed(cop2Proceed),
    .opfHold(opfHold), .aluHold(aluHold), .dacHold(dacHold));
  psec_far_model u_far (.clk_sys(clk_sys), .rst_n(rst_n), .slow(slow), .stall(stall), .cop2Proceed(cop2Proceed),
    .refillDone(refillDone), .opDone(opDone), .cop2Last(cop2Last));
  // ****************
  // checks and steps
  // ****************
  task automatic report_and_stop();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop
  task automatic check_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask : check_bit
  task automatic check_code(input string what, input logic [4:0] exp, input logic [4:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check_code
  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask : step
  task automatic release_req();
    @(posedge clk_sys);
    drv <= '0;
    #1;
  endtask : release_req
  task automatic wait_idle();
    n = 0;
    while ((stall !== '0 || advance !== 1'b1) && n < 40) begin
      step();
      n++;
    end
    check_bit("pipeline resumed", 1'b1, advance);
  endtask : wait_idle
  // 3'h7 as origin skips the origin check, exact 0 skips the delay check
  task automatic run_exc(input logic [4:0] exp, input logic [2:0] from, input int exact);
    #1;
    n = 0;
    while (exc.abortPulse !== 1'b1 && n < 40) begin
      step();
      n++;
    end
    check_code("cause", exp, exc.causeCode);
    if (exact > 0) check_code("abort delay", 5'(exact), 5'(n));
    if (from != 3'h7) check_code("abort origin", {2'h0, from}, {2'h0, exc.abortFrom});
    @(posedge clk_sys);
    {drv, dacExc, aluExc, intrReq, resetReq} <= '0;
    #1;
    check_bit("vector fetch", 1'b1, exc.vectorFetch);
    wait_idle();
  endtask : run_exc
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // ********
  // sequence
  // ********
  initial begin
    repeat (20) step();
    check_bit("hold in reset", 1'b1, dacHold);
    @(posedge clk_sys) rst_n <= 1'b1;
    wait_idle();
    @(posedge clk_sys) drv.multicycleEnter <= 1'b1;
    release_req();
    repeat (2) step();
    check_bit("mc stall", 1'b1, stall.multicycle_stall);
    @(posedge clk_sys) drv.multicycleLast <= 1'b1;
    release_req();
    check_bit("mc advance", 1'b1, advance);
    for (int s = 0; s < 2; s++) begin
      @(posedge clk_sys) begin
        slow <= s[0];
        drv.cop2Enter <= 1'b1;
      end
      release_req();
      check_bit("cop2 go", 1'b1, cop2Proceed);
      wait_idle();
    end
    for (int m = 0; m < 2; m++) begin
      @(posedge clk_sys) begin
        drv.loadUseHazard <= 1'b1;
        drv.dacIsLoad <= 1'b1;
        drv.dacNeedsCache <= 1'b1;
        drv.dcacheLookupMiss <= m[0];
      end
      release_req();
      check_bit("load use", 1'b1, stall.load_use_stall);
      check_bit("miss", m[0], stall.dcache_miss_stall);
      if (m == 1) begin
        step();
        check_bit("busy", 1'b1, stall.dcache_busy_stall);
        n = 0;
        while (stall.dcache_busy_stall === 1'b1 && n < 40) begin
          step();
          n++;
        end
        check_bit("load use tail", 1'b1, stall.load_use_stall);
      end
      step();
      check_bit("load use end", 1'b0, stall.load_use_stall);
      wait_idle();
    end
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys) begin
        drv.icacheOpEnter <= (k == 0);
        drv.dcacheOpEnter <= (k == 1);
      end
      release_req();
      check_bit("maint", 1'b1, stall.cache_maint_stall);
      wait_idle();
    end
    @(posedge clk_sys) drv <= psec_req_t'(18'h3);
    release_req();
    check_bit("bypass", 1'b1, stall.syscop_bypass_stall);
    wait_idle();
    for (int i = 0; i < 12; i++) begin
      @(posedge clk_sys) dacExc <= psec_dac_exc_t'(13'h1 << i);
      run_exc(5'(`PSEC_CAUSE_DBE - i), 3'h7, (i == 1 || i == 11) ? 0 : 4);
    end
    @(posedge clk_sys) dacExc <= psec_dac_exc_t'(13'h0fff);
    run_exc(`PSEC_CAUSE_NMI, 3'h7, 0);
    @(posedge clk_sys) begin
      dacExc.trap <= 1'b1;
      aluExc.syscall <= 1'b1;
      drv.dcacheLookupMiss <= 1'b1;
    end
    run_exc(`PSEC_CAUSE_TRAP, `PSEC_STG_DAC, 4);
    for (int j = 0; j < 4; j++) begin
      @(posedge clk_sys) aluExc <= psec_alu_exc_t'(4'h1 << j);
      run_exc(5'(`PSEC_CAUSE_RSVD - j), `PSEC_STG_ALU, 0);
    end
    @(posedge clk_sys) dacExc.trap <= 1'b1;
    @(posedge clk_sys) drv.multicycleEnter <= 1'b1;
    run_exc(`PSEC_CAUSE_TRAP, `PSEC_STG_DAC, 3);
    check_bit("aborted mc", 1'b0, stall.multicycle_stall);
    @(posedge clk_sys) drv <= psec_req_t'(18'h8);
    release_req();
    @(posedge clk_sys) aluExc.syscall <= 1'b1;
    step();
    check_bit("exc waits", 1'b0, exc.abortPulse);
    run_exc(`PSEC_CAUSE_SYSC, `PSEC_STG_ALU, 0);
    @(posedge clk_sys) drv.multicycleEnter <= 1'b1;
    @(posedge clk_sys) begin
      drv <= '0;
      intrReq <= 1'b1;
    end
    repeat (6) step();
    check_bit("no intr in stall", 1'b1, stall.multicycle_stall);
    @(posedge clk_sys) drv.multicycleLast <= 1'b1;
    @(posedge clk_sys) begin
      drv <= '0;
      intrReq <= 1'b0;
    end
    run_exc(`PSEC_CAUSE_INTR, 3'h7, 0);
    check_bit("intr keeps retire", 1'b1, exc.keepRetire);
    @(posedge clk_sys) resetReq <= 1'b1;
    @(posedge clk_sys) resetReq <= 1'b0;
    run_exc(`PSEC_CAUSE_RESET, 3'h7, 0);
    check_bit("reset keeps retire", 1'b1, exc.keepRetire);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
